// >>> common/sfs_cfg.svh
`ifndef SFS_CFG_SVH
`define SFS_CFG_SVH
`define SFS_CLK_HZ        20000000
`define SFS_SC_FILT_MS    4
`define SFS_RST_DLY_US    1000
`define SFS_BLANK_CYC     5'h10
`define SFS_UV_FS_LAST    3'h3
`define SFS_ADDR_STATUS   12'h000
`define SFS_ADDR_CTRL     12'h004
`define SFS_ADDR_CMD      12'h008
`define SFS_ADDR_STATE    12'h00c
`define SFS_CTRL_RST      7'h00
`define SFS_NSYNC         17
`define SFS_NSTAT         17
`define SFS_IN_BATT_UV    0
`define SFS_IN_HS_UV      1
`define SFS_IN_HS_OV      2
`define SFS_IN_PREWARN    3
`define SFS_IN_MAIN_UV    4
`define SFS_IN_MAIN_OV    5
`define SFS_IN_THIRD_OC   6
`define SFS_IN_THIRD_UV   7
`define SFS_IN_SECOND_UV  8
`define SFS_IN_BUS_UV     9
`define SFS_IN_OT_SECOND  10
`define SFS_IN_OT_THIRD   11
`define SFS_IN_OT_CAN     12
`define SFS_IN_OT_LIN     13
`define SFS_IN_OT_SW      14
`define SFS_IN_FAIL_CFG   15
`define SFS_IN_WAKE       16
`define SFS_ST_BATT_UV    0
`define SFS_ST_HS_UV      1
`define SFS_ST_HS_OV      2
`define SFS_ST_PREWARN    3
`define SFS_ST_MAIN_UV    4
`define SFS_ST_UV_FS      5
`define SFS_ST_MAIN_OV    6
`define SFS_ST_MAIN_SC    7
`define SFS_ST_FAILURE    8
`define SFS_ST_THIRD_OC   9
`define SFS_ST_THIRD_UV   10
`define SFS_ST_SECOND_UV  11
`define SFS_ST_BUS_UV     12
`define SFS_ST_BLOCK_OT   13
`define SFS_ST_SECOND_OT  14
`define SFS_ST_THIRD_OT   15
`define SFS_ST_SWITCH_OT  16
`define SFS_CT_KEEP_BATT  0
`define SFS_CT_OV_RST     1
`define SFS_CT_LS_STOP    2
`define SFS_CT_SECOND_ON  3
`define SFS_CT_THIRD_ON   4
`define SFS_CT_LOAD_SHARE 5
`define SFS_CT_SWITCH_ON  6
`define SFS_CMD_NORMAL    2'h1
`define SFS_CMD_STOP      2'h2
`define SFS_CMD_SLEEP     2'h3
`define SFS_CMD_SOFT_RST  4
`endif

// >>> common/sfs_pkg.sv
package sfs_pkg;
  typedef enum logic [5:0] {
    SFS_INIT     = 6'h01,
    SFS_NORMAL   = 6'h02,
    SFS_STOP     = 6'h04,
    SFS_SLEEP    = 6'h08,
    SFS_RESTART  = 6'h10,
    SFS_FAILSAFE = 6'h20
  } sfs_mode_t;

  typedef logic [16:0] sfs_stat_t;

  // set wins over clear; a held bit ignores the clear
  function automatic sfs_stat_t sfs_w1c(input sfs_stat_t cur, input sfs_stat_t set,
                                        input sfs_stat_t clr, input sfs_stat_t hold);
    sfs_w1c = set | (cur & ~(clr & ~hold));
  endfunction

  function automatic logic [4:0] sfs_blank(input logic [4:0] cnt, input logic changed,
                                           input logic [4:0] len);
    if (changed)
      sfs_blank = len;
    else if (cnt != 5'h00)
      sfs_blank = cnt - 5'h01;
    else
      sfs_blank = 5'h00;
  endfunction
endpackage

// >>> common/sfs_sync_if.sv
`timescale 1ns/1ps
`include "sfs_cfg.svh"
interface sfs_sync_if;
  logic [`SFS_NSYNC-1:0] raw;
  logic [`SFS_NSYNC-1:0] sync;
  modport src (output raw, input sync);
  modport syn (input raw, output sync);
endinterface

// >>> rtl/sfs_sync.sv
`timescale 1ns/1ps
`include "sfs_cfg.svh"
module sfs_sync
  import sfs_pkg::*;
(
  input  wire logic clk_sys_in,
  input  wire logic nrst_in,
  sfs_sync_if.syn   port_in
);
  logic [`SFS_NSYNC-1:0] meta_r;
  logic [`SFS_NSYNC-1:0] sync_r;

  // first stage feeds only the second stage
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      meta_r <= '0;
      sync_r <= '0;
    end
    else
    begin
      meta_r <= port_in.raw;
      sync_r <= meta_r;
    end
  end

  assign port_in.sync = sync_r;
endmodule

// >>> rtl/sfs_top.sv
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`include "sfs_cfg.svh"
module sfs_top
  import sfs_pkg::*;
#(
  parameter int unsigned SC_FILT_CYC = `SFS_CLK_HZ / 1000 * `SFS_SC_FILT_MS,
  parameter int unsigned RST_DLY_CYC = `SFS_CLK_HZ / 1000000 * `SFS_RST_DLY_US
)
(
  input  wire logic        clk_sys_in,
  input  wire logic        nrst_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic [`SFS_NSYNC-1:0] monitors_in,
  output logic             reset_output_n_out,
  output logic             fail_outputs_out,
  output logic             main_reg_en_out,
  output logic             second_reg_en_out,
  output logic             third_reg_en_out,
  output logic             lin_tx_en_out,
  output logic             lin_rx_en_out,
  output logic             can_tx_en_out,
  output logic             highside_switches_en_out
);
  sfs_sync_if sync_bus ();
  assign sync_bus.raw = monitors_in;

  sfs_sync u_sync (
    .clk_sys_in (clk_sys_in),
    .nrst_in    (nrst_in),
    .port_in    (sync_bus.syn)
  );

  logic [`SFS_NSYNC-1:0] mon;
  logic [`SFS_NSYNC-1:0] mon_prev_r;
  assign mon = sync_bus.sync;

  sfs_mode_t   mode_r;
  sfs_mode_t   mode_nxt;
  sfs_stat_t   status_r;
  sfs_stat_t   st_set;
  sfs_stat_t   st_clr;
  sfs_stat_t   st_hold;
  logic [6:0]  ctrl_r;
  logic [2:0]  uv_cnt_r;
  logic [19:0] sc_cnt_r;
  logic [19:0] rd_cnt_r;
  logic [4:0]  blk2_r;
  logic [4:0]  blk3_r;
  logic        fail_r;
  logic        main_off_r;
  logic        pready_r;
  logic        pslverr_r;
  logic [31:0] prdata_r;
  logic [31:0] rd_data;
  logic        mapped;

  // bus side
  logic access;
  logic wr_fire;
  logic wr_status;
  logic wr_ctrl;
  logic wr_cmd;
  assign access    = psel_in & penable_in;
  assign wr_fire   = access & pready_r & pwrite_in;
  assign wr_status = wr_fire & (paddr_in == `SFS_ADDR_STATUS);
  assign wr_ctrl   = wr_fire & (paddr_in == `SFS_ADDR_CTRL);
  assign wr_cmd    = wr_fire & (paddr_in == `SFS_ADDR_CMD);

  // monitor decode
  logic batt_uv;
  logic main_uv;
  logic ot_second;
  logic ot_third;
  logic ot_can;
  logic ot_lin;
  logic ot_sw;
  logic standalone;
  logic is_sleep;
  logic is_active3;
  logic uv_ev;
  logic cnt_inc;
  logic uv_fs_ev;
  logic ov_ev;
  logic ov_rst_ev;
  logic ov_fs_ev;
  logic sc_run;
  logic sc_ev;
  logic rd_done;
  logic soft_rst;
  logic fs_enter;
  logic [1:0] cmd;
  assign batt_uv    = mon[`SFS_IN_BATT_UV];
  assign main_uv    = mon[`SFS_IN_MAIN_UV];
  assign ot_second  = mon[`SFS_IN_OT_SECOND];
  assign ot_third   = mon[`SFS_IN_OT_THIRD];
  assign ot_can     = mon[`SFS_IN_OT_CAN];
  assign ot_lin     = mon[`SFS_IN_OT_LIN];
  assign ot_sw      = mon[`SFS_IN_OT_SW];
  assign standalone = ~ctrl_r[`SFS_CT_LOAD_SHARE];
  assign is_sleep   = (mode_r == SFS_SLEEP);
  assign is_active3 = (mode_r == SFS_INIT) | (mode_r == SFS_NORMAL) | (mode_r == SFS_STOP);
  assign cmd        = pwdata_in[1:0];
  assign soft_rst   = wr_cmd & pwdata_in[`SFS_CMD_SOFT_RST];

  // main low only counts as an event where the regulator is expected up
  assign uv_ev    = main_uv & ~mon_prev_r[`SFS_IN_MAIN_UV] & ~is_sleep
                  & (mode_r != SFS_FAILSAFE);
  assign cnt_inc  = uv_ev & is_active3 & ~((mode_r == SFS_NORMAL) & batt_uv);
  assign uv_fs_ev = cnt_inc & (uv_cnt_r == `SFS_UV_FS_LAST);
  assign ov_ev    = mon[`SFS_IN_MAIN_OV] & ~mon_prev_r[`SFS_IN_MAIN_OV]
                  & ((mode_r == SFS_INIT) | (mode_r == SFS_NORMAL));
  assign ov_rst_ev = ov_ev & ctrl_r[`SFS_CT_OV_RST] & mon[`SFS_IN_FAIL_CFG];
  assign ov_fs_ev  = ov_ev & ctrl_r[`SFS_CT_OV_RST] & ~mon[`SFS_IN_FAIL_CFG];
  // battery low disarms the short filter
  assign sc_run   = main_uv & ~batt_uv & ~main_off_r & ~is_sleep
                  & (mode_r != SFS_FAILSAFE);
  assign sc_ev    = sc_run & (sc_cnt_r == 20'(SC_FILT_CYC - 1));
  assign rd_done  = (mode_r == SFS_RESTART) & ~main_uv & (rd_cnt_r == 20'(RST_DLY_CYC - 1));
  assign fs_enter = sc_ev | uv_fs_ev | ov_fs_ev;

  always_comb
  begin
    mode_nxt = mode_r;
    if (fs_enter)
      mode_nxt = SFS_FAILSAFE;
    else if ((uv_ev & is_active3) | ov_rst_ev)
      mode_nxt = SFS_RESTART;
    else
    begin
      case (mode_r)
        SFS_INIT, SFS_NORMAL, SFS_STOP:
        begin
          if (wr_cmd & (cmd == `SFS_CMD_NORMAL))
            mode_nxt = SFS_NORMAL;
          else if (wr_cmd & (cmd == `SFS_CMD_STOP))
            mode_nxt = SFS_STOP;
          else if (wr_cmd & (cmd == `SFS_CMD_SLEEP))
            mode_nxt = SFS_SLEEP;
        end
        SFS_RESTART:
          if (rd_done)
            mode_nxt = SFS_NORMAL;
        SFS_SLEEP, SFS_FAILSAFE:
          if (mon[`SFS_IN_WAKE])
            mode_nxt = SFS_RESTART;
        default:
          mode_nxt = SFS_INIT;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      mode_r     <= SFS_INIT;
      mon_prev_r <= '0;
    end
    else
    begin
      mode_r     <= mode_nxt;
      mon_prev_r <= mon;
    end
  end

  // short filter and reset delay
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      sc_cnt_r <= 20'h00000;
      rd_cnt_r <= 20'h00000;
    end
    else
    begin
      sc_cnt_r <= (sc_run & ~sc_ev) ? sc_cnt_r + 20'h00001 : 20'h00000;
      rd_cnt_r <= ((mode_r == SFS_RESTART) & ~main_uv & ~rd_done) ?
                  rd_cnt_r + 20'h00001 : 20'h00000;
    end
  end

  // consecutive low counter
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
      uv_cnt_r <= 3'h0;
    else if (fs_enter | soft_rst)
      uv_cnt_r <= 3'h0;
    else if (cnt_inc)
      uv_cnt_r <= uv_cnt_r + 3'h1;
    else if (wr_status & pwdata_in[`SFS_ST_MAIN_UV] & status_r[`SFS_ST_MAIN_UV])
      uv_cnt_r <= 3'h0;
  end

  // main regulator off after a short, back on with the wake
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
      main_off_r <= 1'b0;
    else if (sc_ev)
      main_off_r <= 1'b1;
    else if ((mode_r == SFS_FAILSAFE) & mon[`SFS_IN_WAKE])
      main_off_r <= 1'b0;
  end

  // fail outputs stay on until software acknowledges in normal mode
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
      fail_r <= 1'b0;
    else if (fs_enter | ov_rst_ev)
      fail_r <= 1'b1;
    else if (wr_status & pwdata_in[`SFS_ST_FAILURE] & (mode_r == SFS_NORMAL))
      fail_r <= 1'b0;
  end

  // switch-on blanking for the regulator low comparators
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      blk2_r <= 5'h00;
      blk3_r <= 5'h00;
    end
    else
    begin
      blk2_r <= sfs_blank(blk2_r, second_reg_en_out ^ ctrl_r[`SFS_CT_SECOND_ON],
                          `SFS_BLANK_CYC);
      blk3_r <= sfs_blank(blk3_r, third_reg_en_out ^ ctrl_r[`SFS_CT_THIRD_ON],
                          `SFS_BLANK_CYC);
    end
  end

  // control register; hardware clears win over software writes
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
      ctrl_r <= `SFS_CTRL_RST;
    else
    begin
      if (wr_ctrl)
        ctrl_r <= pwdata_in[6:0];
      if (ov_rst_ev)
        ctrl_r[`SFS_CT_OV_RST] <= 1'b0;
      if (ot_second & ctrl_r[`SFS_CT_SECOND_ON])
        ctrl_r[`SFS_CT_SECOND_ON] <= 1'b0;
      if (ot_third & standalone & ctrl_r[`SFS_CT_THIRD_ON])
        ctrl_r[`SFS_CT_THIRD_ON] <= 1'b0;
      if (ot_sw & ctrl_r[`SFS_CT_SWITCH_ON])
        ctrl_r[`SFS_CT_SWITCH_ON] <= 1'b0;
    end
  end

  // status flags
  always_comb
  begin
    st_set  = '0;
    st_hold = '0;
    st_set[`SFS_ST_BATT_UV]   = batt_uv;
    st_hold[`SFS_ST_BATT_UV]  = batt_uv;
    st_set[`SFS_ST_HS_UV]     = mon[`SFS_IN_HS_UV];
    st_hold[`SFS_ST_HS_UV]    = mon[`SFS_IN_HS_UV];
    st_set[`SFS_ST_HS_OV]     = mon[`SFS_IN_HS_OV];
    st_hold[`SFS_ST_HS_OV]    = mon[`SFS_IN_HS_OV];
    st_set[`SFS_ST_PREWARN]   = mon[`SFS_IN_PREWARN] & ~is_sleep;
    st_set[`SFS_ST_MAIN_UV]   = uv_ev;
    st_set[`SFS_ST_UV_FS]     = uv_fs_ev;
    st_set[`SFS_ST_MAIN_OV]   = ov_ev;
    st_set[`SFS_ST_MAIN_SC]   = sc_ev;
    st_set[`SFS_ST_FAILURE]   = fs_enter | ov_rst_ev;
    st_hold[`SFS_ST_FAILURE]  = (mode_r != SFS_NORMAL);
    st_set[`SFS_ST_THIRD_OC]  = standalone & ctrl_r[`SFS_CT_THIRD_ON]
                              & mon[`SFS_IN_THIRD_OC];
    st_set[`SFS_ST_THIRD_UV]  = standalone & third_reg_en_out & (blk3_r == 5'h00)
                              & mon[`SFS_IN_THIRD_UV];
    st_set[`SFS_ST_SECOND_UV] = second_reg_en_out & (blk2_r == 5'h00)
                              & mon[`SFS_IN_SECOND_UV];
    st_set[`SFS_ST_BUS_UV]    = mon[`SFS_IN_BUS_UV];
    st_set[`SFS_ST_BLOCK_OT]  = (ot_second & ctrl_r[`SFS_CT_SECOND_ON]) | ot_can | ot_lin
                              | (ot_sw & ctrl_r[`SFS_CT_SWITCH_ON]);
    st_hold[`SFS_ST_BLOCK_OT] = ot_second | ot_can | ot_lin | ot_sw;
    st_set[`SFS_ST_SECOND_OT] = ot_second & ctrl_r[`SFS_CT_SECOND_ON];
    st_hold[`SFS_ST_SECOND_OT] = ot_second;
    st_set[`SFS_ST_THIRD_OT]  = ot_third & ctrl_r[`SFS_CT_THIRD_ON];
    st_hold[`SFS_ST_THIRD_OT] = ot_third;
    st_set[`SFS_ST_SWITCH_OT] = ot_sw & ctrl_r[`SFS_CT_SWITCH_ON];
    st_hold[`SFS_ST_SWITCH_OT] = ot_sw;
    st_clr  = wr_status ? pwdata_in[16:0] : '0;
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
      status_r <= '0;
    else
      status_r <= sfs_w1c(status_r, st_set, st_clr, st_hold);
  end

  // pin drivers, all registered
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      reset_output_n_out       <= 1'b0;
      main_reg_en_out          <= 1'b0;
      second_reg_en_out        <= 1'b0;
      third_reg_en_out         <= 1'b0;
      lin_tx_en_out            <= 1'b0;
      lin_rx_en_out            <= 1'b0;
      can_tx_en_out            <= 1'b0;
      highside_switches_en_out <= 1'b0;
    end
    else
    begin
      reset_output_n_out       <= is_active3 & ~(uv_ev & is_active3);
      main_reg_en_out          <= ~is_sleep & ~main_off_r & ~sc_ev;
      second_reg_en_out        <= ctrl_r[`SFS_CT_SECOND_ON] & ~ot_second;
      // same pin drives the pass transistor in either configuration
      third_reg_en_out         <= ctrl_r[`SFS_CT_THIRD_ON] & ~ot_third
                                & ~(batt_uv & ~ctrl_r[`SFS_CT_KEEP_BATT])
                                & ~(~standalone & (mode_r == SFS_STOP)
                                    & ~ctrl_r[`SFS_CT_LS_STOP]);
      lin_tx_en_out            <= ~mon[`SFS_IN_HS_UV] & ~ot_lin;
      lin_rx_en_out            <= ~mon[`SFS_IN_HS_UV];
      can_tx_en_out            <= ~ot_can;
      highside_switches_en_out <= ctrl_r[`SFS_CT_SWITCH_ON] & ~ot_sw;
    end
  end

  assign fail_outputs_out = fail_r;

  // read mux
  always_comb
  begin
    rd_data = 32'h0000_0000;
    mapped  = 1'b1;
    case (paddr_in)
      `SFS_ADDR_STATUS: rd_data[16:0] = status_r;
      `SFS_ADDR_CTRL:   rd_data[6:0]  = ctrl_r;
      `SFS_ADDR_CMD:    rd_data       = 32'h0000_0000;
      `SFS_ADDR_STATE:
      begin
        rd_data[5:0]   = mode_r;
        rd_data[10:8]  = uv_cnt_r;
        rd_data[13:12] = ot_lin ? 2'h1 : 2'h0;
      end
      default:          mapped = 1'b0;
    endcase
  end

  // one wait state: ready rises the cycle after the access phase opens
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end
    else
    begin
      pready_r  <= access & ~pready_r;
      pslverr_r <= access & ~pready_r & ~mapped;
      prdata_r  <= (access & ~pready_r & ~pwrite_in) ? rd_data : 32'h0000_0000;
    end
  end

  assign pready_out  = pready_r;
  assign pslverr_out = pslverr_r;
  assign prdata_out  = prdata_r;
endmodule

// >>> tb/sfs_top_props.sv
`timescale 1ns/1ps
`include "sfs_cfg.svh"
module sfs_top_props
#(
  parameter int unsigned SC_FILT_CYC = 80000,
  parameter int unsigned RST_DLY_CYC = 20000
)
(
  input wire logic                  clk_sys_in,
  input wire logic                  nrst_in,
  input wire logic                  psel_in,
  input wire logic                  penable_in,
  input wire logic                  pwrite_in,
  input wire logic [11:0]           paddr_in,
  input wire logic [31:0]           pwdata_in,
  input wire logic [31:0]           prdata_out,
  input wire logic                  pready_out,
  input wire logic                  pslverr_out,
  input wire logic [`SFS_NSYNC-1:0] monitors_in,
  input wire logic                  reset_output_n_out,
  input wire logic                  fail_outputs_out,
  input wire logic                  main_reg_en_out,
  input wire logic                  second_reg_en_out,
  input wire logic                  third_reg_en_out,
  input wire logic                  lin_tx_en_out,
  input wire logic                  lin_rx_en_out,
  input wire logic                  can_tx_en_out,
  input wire logic                  highside_switches_en_out
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!nrst_in);

  apb_wait_a: assert property (psel_in && penable_in && !pready_out |=> pready_out)
    else $error("no ready after one wait state");
  ready_pulse_a: assert property (pready_out |=> !pready_out)
    else $error("ready longer than one cycle");
  rd_idle_a: assert property (!pready_out |-> prdata_out == 32'h0)
    else $error("read data outside ready");
  err_map_a: assert property (pslverr_out |-> pready_out && paddr_in > 12'h00c)
    else $error("error on mapped address");
  sync_delay_a: assert property ($rose(monitors_in[1]) && lin_tx_en_out |=> lin_tx_en_out)
    else $error("input used before synchroniser");
  hs_low_lin_a: assert property (monitors_in[1] [*5] |-> !lin_tx_en_out && !lin_rx_en_out)
    else $error("lin enabled at supply low");
  main_low_rst_a: assert property (monitors_in[4] [*5] |-> !reset_output_n_out)
    else $error("reset output high at main low");
  fail_reset_a: assert property ($rose(fail_outputs_out) |=> !reset_output_n_out)
    else $error("fail outputs without mode change");
  fail_clear_a: assert property ($fell(fail_outputs_out) |->
    $past(pready_out && pwrite_in && paddr_in == `SFS_ADDR_STATUS))
    else $error("fail outputs dropped without host clear");
endmodule

// >>> tb/sfs_host.sv
`timescale 1ns/1ps
module sfs_host
(
  input  wire logic        clk_sys_in,
  input  wire logic [31:0] prdata_in,
  input  wire logic        pready_in,
  input  wire logic        pslverr_in,
  output logic             psel_out,
  output logic             penable_out,
  output logic             pwrite_out,
  output logic [11:0]      paddr_out,
  output logic [31:0]      pwdata_out,
  output logic             hung_out
);
  initial
  begin
    psel_out = 1'b0;
    penable_out = 1'b0;
    pwrite_out = 1'b0;
    paddr_out = 12'h000;
    pwdata_out = 32'h0;
    hung_out = 1'b0;
  end

  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
    int n;
    @(posedge clk_sys_in);
    psel_out <= 1'b1;
    pwrite_out <= wr;
    paddr_out <= a;
    pwdata_out <= d;
    @(posedge clk_sys_in);
    penable_out <= 1'b1;
    n = 0;
    // ready is looked at mid-cycle where it has settled; it stands up to the next rising edge
    do
    begin
      @(negedge clk_sys_in);
      n++;
    end
    while (pready_in !== 1'b1 && n < 50);
    q = prdata_in;
    err = pslverr_in;
    @(posedge clk_sys_in);
    if (n >= 50)
      hung_out <= 1'b1;
    psel_out <= 1'b0;
    penable_out <= 1'b0;
    // released data shows a changed pattern, not a stale copy
    pwdata_out <= ~d;
    // outputs launched at the commit edge settle before the caller looks
    @(negedge clk_sys_in);
  endtask
endmodule

// >>> tb/sfs_top_test.sv
`timescale 1ns/1ps
`include "sfs_cfg.svh"
module sfs_top_test;
  localparam int unsigned SC = 20;
  localparam int unsigned RD = 10;
  localparam logic [11:0] A_ST = `SFS_ADDR_STATUS;
  localparam logic [11:0] A_CT = `SFS_ADDR_CTRL;
  localparam logic [11:0] A_CM = `SFS_ADDR_CMD;
  localparam logic [11:0] A_MS = `SFS_ADDR_STATE;
  logic clk_sys_in, nrst_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out, hung;
  logic reset_output_n_out, fail_outputs_out, main_reg_en_out, second_reg_en_out;
  logic third_reg_en_out, lin_tx_en_out, lin_rx_en_out, can_tx_en_out, highside_switches_en_out;
  logic [11:0]           paddr_in;
  logic [31:0]           pwdata_in, prdata_out, q, seed;
  logic [`SFS_NSYNC-1:0] monitors_in;
  logic                  e;
  int                    fails, tests_run, cnt;

  sfs_top #(.SC_FILT_CYC(SC), .RST_DLY_CYC(RD)) sfs_top_inst (.clk_sys_in, .nrst_in, .psel_in,
    .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
    .monitors_in, .reset_output_n_out, .fail_outputs_out, .main_reg_en_out, .second_reg_en_out,
    .third_reg_en_out, .lin_tx_en_out, .lin_rx_en_out, .can_tx_en_out, .highside_switches_en_out);
  sfs_host sfs_host_inst (.clk_sys_in, .prdata_in(prdata_out), .pready_in(pready_out),
    .pslverr_in(pslverr_out), .psel_out(psel_in), .penable_out(penable_in),
    .pwrite_out(pwrite_in), .paddr_out(paddr_in), .pwdata_out(pwdata_in), .hung_out(hung));

  always #25 clk_sys_in = ~clk_sys_in;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic close_out;
    if (fails == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    sfs_host_inst.xfer(1'b1, a, d, q, e);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    sfs_host_inst.xfer(1'b0, a, 32'h0, q, e);
    check(q, exp);
  endtask

  task automatic mon_set(input int b, input logic v);
    @(posedge clk_sys_in);
    monitors_in[b] <= v;
    // two sync stages plus the output flop
    repeat (4) @(posedge clk_sys_in);
  endtask

  task automatic pulse(input int b);
    mon_set(b, 1'b1);
    mon_set(b, 1'b0);
  endtask

  task automatic wait_state(input logic [31:0] exp);
    for (int i = 0; i < 100; i++)
    begin
      sfs_host_inst.xfer(1'b0, A_MS, 32'h0, q, e);
      if (q === exp)
        break;
    end
    check(q, exp);
  endtask

  always @(posedge hung)
  begin
    fails++;
    close_out();
  end

  initial
  begin
    #(50 * 100000);
    fails++;
    close_out();
  end

  initial
  begin
    clk_sys_in = 1'b0;
    nrst_in = 1'b0;
    monitors_in = '0;
    seed = 32'h00014704;
    fails = 0;
    tests_run = 0;
    cnt = 0;
    repeat (12) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    rdc(A_CT, 32'h0);
    wait_state(32'h1);
    sfs_host_inst.xfer(1'b0, 12'h010, 32'h0, q, e);
    check(q, 32'h0);
    check(32'(e), 32'h1);
    for (int i = 0; i < 4; i++)
    begin
      seed = lfsr(seed);
      wr(A_CT, seed & 32'h7f);
      rdc(A_CT, seed & 32'h7f);
    end
    wr(A_CT, 32'h10);
    for (int b = 0; b < 3; b++)
    begin
      mon_set(b, 1'b1);
      rdc(A_ST, 32'h1 << b);
      wr(A_ST, 32'h1 << b);
      rdc(A_ST, 32'h1 << b);
      if (b == 0)
      begin
        check(32'(third_reg_en_out), 32'h0);
        wr(A_CT, 32'h11);
        repeat (2) @(posedge clk_sys_in);
        check(32'(third_reg_en_out), 32'h1);
        wr(A_CT, 32'h10);
      end
      if (b == 1)
        check(32'({lin_tx_en_out, lin_rx_en_out}), 32'h0);
      if (b == 2)
        check(32'({main_reg_en_out, lin_tx_en_out, lin_rx_en_out}), 32'h7);
      mon_set(b, 1'b0);
      check(32'(third_reg_en_out), 32'h1);
      wr(A_ST, 32'h1 << b);
      rdc(A_ST, 32'h0);
    end
    pulse(3);
    rdc(A_ST, 32'h8);
    rdc(A_MS, 32'h1);
    wr(A_ST, 32'h8);
    wr(A_CM, 32'h1);
    wait_state(32'h2);
    wr(A_CT, 32'h8);
    repeat (2) @(posedge clk_sys_in);
    check(32'(second_reg_en_out), 32'h1);
    mon_set(10, 1'b1);
    check(32'(second_reg_en_out), 32'h0);
    rdc(A_CT, 32'h0);
    wr(A_ST, 32'h6000);
    rdc(A_ST, 32'h6000);
    mon_set(10, 1'b0);
    wr(A_ST, 32'h6000);
    rdc(A_ST, 32'h0);
    wr(A_CT, 32'h40);
    repeat (2) @(posedge clk_sys_in);
    check(32'({highside_switches_en_out, can_tx_en_out}), 32'h3);
    mon_set(14, 1'b1);
    mon_set(12, 1'b1);
    check(32'({highside_switches_en_out, can_tx_en_out}), 32'h0);
    rdc(A_CT, 32'h0);
    rdc(A_ST, 32'h12000);
    mon_set(14, 1'b0);
    mon_set(12, 1'b0);
    check(32'({highside_switches_en_out, can_tx_en_out}), 32'h1);
    wr(A_ST, 32'h12000);
    rdc(A_ST, 32'h0);
    // model of the consecutive main-low counter
    for (int i = 1; i <= 4; i++)
    begin
      pulse(4);
      cnt = (i == 4) ? 0 : i;
      wait_state((i == 4) ? 32'h20 : (32'h2 | (cnt << 8)));
    end
    rdc(A_ST, 32'h130);
    check(32'(fail_outputs_out), 32'h1);
    pulse(16);
    wait_state(32'h2);
    wr(A_ST, 32'h1ffff);
    mon_set(0, 1'b1);
    pulse(4);
    wait_state(32'h2);
    mon_set(0, 1'b0);
    pulse(4);
    wait_state(32'h102);
    wr(A_ST, 32'h11);
    wait_state(32'h2);
    rdc(A_ST, 32'h0);
    for (int c = 1; c >= 0; c--)
    begin
      wr(A_CT, 32'h2);
      mon_set(15, c[0]);
      pulse(5);
      check(32'(fail_outputs_out), 32'h1);
      if (c == 1)
      begin
        wait_state(32'h2);
        rdc(A_CT, 32'h0);
      end
      else
      begin
        wait_state(32'h20);
        pulse(16);
        wait_state(32'h2);
      end
      rdc(A_ST, 32'h140);
      wr(A_ST, 32'h1ffff);
      check(32'(fail_outputs_out), 32'h0);
    end
    wr(A_CT, 32'h0);
    wr(A_CM, 32'h2);
    wait_state(32'h4);
    pulse(4);
    wait_state(32'h102);
    wr(A_CM, 32'h10);
    wait_state(32'h2);
    wr(A_ST, 32'h1ffff);
    wr(A_CM, 32'h3);
    pulse(4);
    pulse(3);
    check(32'({main_reg_en_out, reset_output_n_out}), 32'h0);
    rdc(A_ST, 32'h0);
    pulse(16);
    wait_state(32'h2);
    mon_set(0, 1'b1);
    mon_set(4, 1'b1);
    repeat (SC + 10) @(posedge clk_sys_in);
    rdc(A_MS, 32'h10);
    mon_set(4, 1'b0);
    mon_set(0, 1'b0);
    wait_state(32'h2);
    wr(A_ST, 32'h1ffff);
    mon_set(4, 1'b1);
    repeat (SC + 10) @(posedge clk_sys_in);
    wait_state(32'h20);
    check(32'({main_reg_en_out, fail_outputs_out}), 32'h1);
    rdc(A_ST, 32'h190);
    mon_set(4, 1'b0);
    pulse(16);
    wait_state(32'h2);
    check(32'(main_reg_en_out), 32'h1);
    wr(A_ST, 32'h1ffff);
    check(32'(fail_outputs_out), 32'h0);
    close_out();
  end
endmodule

bind sfs_top sfs_top_props #(.SC_FILT_CYC(SC_FILT_CYC), .RST_DLY_CYC(RST_DLY_CYC))
  sfs_top_props_inst (.clk_sys_in, .nrst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
  .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .monitors_in, .reset_output_n_out,
  .fail_outputs_out, .main_reg_en_out, .second_reg_en_out, .third_reg_en_out, .lin_tx_en_out,
  .lin_rx_en_out, .can_tx_en_out, .highside_switches_en_out);
